/* File: rtl/cdd_receiver.sv */
// download-to-controller command handler with chunk store
//
// Behaviour
// - every good download command (code 0x4C, checksum, identifier ok) gets a 0xCC response.
// - command code 0x4C is the package download command.
// - unsupported data handle ends the transfer with reason 0x4C02.
// - chunks are kept in the order they were sent.
// - may ask to resend the active chunk, never an earlier one.
// - block is handed on only after every chunk arrived cleanly.
// - either side may abort; sender by opcode, controller by reason.
// - lost context or out-of-order chunk number aborts the transfer.
// - an aborted transfer is failed and cannot be resumed.
// - only one transfer sequence, upload or download, at a time.
// - response holds response and reason code in bytes 16..19.
// - unspecified termination reports reason 0x4C01.
// - non-consecutive chunk number reports 0x4C03 and aborts.
// - no room to store data reports reason 0x4C04.
`timescale 1ns/1ns

module cdd_receiver
  import cdd_pkg::*;
(
  input  wire logic        ref_clk,      // 10 MHz clock
  input  wire logic        arst_n,       // async reset, active low
  input  wire logic        dataValid,    // payload word strobe
  input  wire logic [31:0] dataWord,     // payload word
  input  wire logic        cmdValid,     // command trailer strobe
  input  wire cdd_cmd_t    cmd,          // decoded command fields
  input  wire logic        otherBusy,    // upload engine has a transfer
  output logic             respValid,    // response strobe
  output cdd_rsp_t         resp,         // response fields
  output logic [31:0]      respWord,     // bytes 16..19 of response
  output logic             xferActive,   // download sequence open
  output logic             blockReady,   // block complete pulse
  input  wire logic [7:0]  regAddr,      // register byte address
  input  wire logic [31:0] regWdata,     // register write data
  input  wire logic        regWr,        // register write strobe
  input  wire logic        regRd,        // register read strobe
  output logic [31:0]      regRdata      // read data, cycle after
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstMeta_q;
  logic rstSync_q;

  // two stages so release never lands mid-cycle on the core
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cdd_state_t  state_q,  state_d;
  logic [31:0] expect_q, expect_d;
  logic [31:0] offset_q, offset_d;
  logic [6:0]  commit_q, commit_d;
  logic [6:0]  stage_q;
  logic        stageOvf_q;
  logic [2:0]  ctrl_q;
  logic [31:0] handle_q;
  logic [MEM_AW-1:0] rdIdx_q;
  logic        respValid_q;
  cdd_rsp_t    resp_q,   resp_d;
  logic        ready_q;
  logic        actOut_q;
  logic [31:0] rdData_q;
  logic [31:0] mem [MEM_DEPTH];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic isOp(input logic [7:0] op,
                                input logic [7:0] want);
    isOp = (op == want);
  endfunction : isOp

  wire logic take     = cmdValid && cmd.chkOk && cmd.idOk
                        && (cmd.cmdCode == CMD_DOWNLOAD);
  wire logic opFirst  = isOp(cmd.opcode, OP_FIRST)
                        || isOp(cmd.opcode, OP_ONLY);
  wire logic opLast   = isOp(cmd.opcode, OP_FINAL)
                        || isOp(cmd.opcode, OP_ONLY);
  wire logic opNext   = isOp(cmd.opcode, OP_MIDDLE)
                        || isOp(cmd.opcode, OP_FINAL);
  wire logic opAbort  = isOp(cmd.opcode, OP_ABORT);
  wire logic active   = (state_q == ST_ACTIVE);
  wire logic handleOk = ctrl_q[CTRL_ANYH_BIT]
                        || (cmd.handleChunk == handle_q);
  wire logic seqOk    = (cmd.handleChunk == expect_q);
  wire logic roomOk   = ctrl_q[CTRL_STORE_BIT] && !stageOvf_q;
  wire logic busyNew  = active || otherBusy;
  wire logic [6:0] stageBase = active ? commit_q : 7'h00;
  wire logic [7:0] stageAddr = {1'b0, stageBase} + {1'b0, stage_q};
  wire logic stageFits = (stageAddr < {1'b0, MEM_WORDS});

  // ---------------------------------------------------------------
  // command decision
  // ---------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    expect_d = expect_q;
    offset_d = offset_q;
    commit_d = commit_q;
    resp_d   = '{rspType: RSP_DOWNLOAD, respCode: RC_OK,
                 reason: RSN_NONE};
    if (opFirst) begin
      if (busyNew) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_ABORT;
      end else if (!handleOk) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_HANDLE;
        state_d         = ST_IDLE;
      end else if (!roomOk) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_STORAGE;
        state_d         = ST_IDLE;
      end else if (cmd.partialWord && !opLast) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_RESEND;
      end else begin
        commit_d = stage_q;
        offset_d = cmd.offset;
        expect_d = SEQ_SECOND;
        state_d  = opLast ? ST_DONE : ST_ACTIVE;
      end
    end else if (opNext) begin
      if (!active) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_ABORT;
      end else if (!seqOk) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_SEQ;
        state_d         = ST_IDLE;
      end else if (!roomOk) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_STORAGE;
        state_d         = ST_IDLE;
      end else if (cmd.partialWord && !opLast) begin
        resp_d.respCode = RC_FAIL;
        resp_d.reason   = RSN_RESEND;
      end else begin
        commit_d = 7'(commit_q + stage_q);
        expect_d = expect_q + SEQ_STEP;
        state_d  = opLast ? ST_DONE : ST_ACTIVE;
      end
    end else if (opAbort) begin
      state_d = ST_IDLE;
    end else begin
      resp_d.respCode = RC_FAIL;
      resp_d.reason   = RSN_BADOP;
    end
  end

  // ---------------------------------------------------------------
  // sequence registers
  // ---------------------------------------------------------------
  // reset drops context, so a later chunk is refused
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q  <= ST_IDLE;
      expect_q <= '0;
      offset_q <= '0;
      commit_q <= '0;
    end else if (take) begin
      state_q  <= state_d;
      expect_q <= expect_d;
      offset_q <= offset_d;
      commit_q <= commit_d;
    end else if (regWr && regAddr == REG_CTRL
                 && regWdata[CTRL_CLEAR_BIT]
                 && state_q == ST_DONE) begin
      state_q <= ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // chunk staging
  // ---------------------------------------------------------------
  // words land past the commit point while a transfer is active, else from word 0;
  // a refused chunk is simply forgotten, so earlier chunks of the open transfer are never disturbed
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      stage_q    <= '0;
      stageOvf_q <= 1'b0;
    end else if (cmdValid) begin
      stage_q    <= '0;
      stageOvf_q <= 1'b0;
    end else if (dataValid) begin
      if (stageFits) begin
        stage_q <= 7'(stage_q + 7'h01);
      end else begin
        stageOvf_q <= 1'b1;
      end
    end
  end

  // storage array, no reset needed for data words
  always_ff @(posedge ref_clk) begin
    if (dataValid && stageFits) begin
      mem[stageAddr[MEM_AW-1:0]] <= dataWord;
    end
  end

  // ---------------------------------------------------------------
  // response and completion
  // ---------------------------------------------------------------
  // completion keys on an accepted last chunk, so a block that
  // follows a finished one from the done state still pulses
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      respValid_q <= 1'b0;
      resp_q      <= '0;
      ready_q     <= 1'b0;
      actOut_q    <= 1'b0;
    end else begin
      respValid_q <= take;
      ready_q     <= take && resp_d.respCode == RC_OK
                     && state_d == ST_DONE;
      actOut_q    <= take ? (state_d == ST_ACTIVE) : active;
      if (take) begin
        resp_q <= resp_d;
      end
    end
  end

  assign respValid  = respValid_q;
  assign resp       = resp_q;
  assign respWord   = {resp_q.respCode, resp_q.reason};
  assign blockReady = ready_q;
  assign xferActive = actOut_q;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  wire logic [31:0] statusWord = {28'h0, stageOvf_q, otherBusy,
                                  state_q};
  wire logic [31:0] rdMux =
      (regAddr == REG_CTRL)   ? {29'h0, ctrl_q}         :
      (regAddr == REG_HANDLE) ? handle_q                :
      (regAddr == REG_STATUS) ? statusWord              :
      (regAddr == REG_EXPECT) ? expect_q                :
      (regAddr == REG_LEN)    ? {25'h0, commit_q}       :
      (regAddr == REG_RDIDX)  ? {26'h0, rdIdx_q}        :
      (regAddr == REG_RDDATA) ? mem[rdIdx_q]            :
      (regAddr == REG_OFFSET) ? offset_q                : 32'h0;

  // clear bit is a command, it is not kept
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ctrl_q   <= CTRL_RESET;
      handle_q <= '0;
      rdIdx_q  <= '0;
      rdData_q <= '0;
    end else begin
      rdData_q <= regRd ? rdMux : 32'h0;
      if (regWr && regAddr == REG_CTRL) begin
        ctrl_q <= {1'b0, regWdata[CTRL_ANYH_BIT:CTRL_STORE_BIT]};
      end
      if (regWr && regAddr == REG_HANDLE) begin
        handle_q <= regWdata;
      end
      if (regWr && regAddr == REG_RDIDX) begin
        rdIdx_q <= regWdata[MEM_AW-1:0];
      end
    end
  end

  assign regRdata = rdData_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_resp_follows_cmd: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q) take |=> respValid_q)
    else $error("good command got no response");

  a_resp_only_good: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    respValid_q |-> $past(cmdValid) && $past(cmd.chkOk)
    && $past(cmd.idOk) && resp_q.rspType == RSP_DOWNLOAD)
    else $error("response without a good command");

  a_handle_reject: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opFirst && !busyNew && !handleOk
    |=> resp_q.reason == RSN_HANDLE && !xferActive)
    else $error("bad handle not refused");

  a_seq_abort: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opNext && active && !seqOk
    |=> resp_q.reason == RSN_SEQ && state_q == ST_IDLE)
    else $error("sequence error did not abort");

  a_expect_start: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opFirst && !opLast && resp_d.respCode == RC_OK
    |=> expect_q == SEQ_SECOND && xferActive)
    else $error("expected chunk not set to two");

  a_expect_step: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opNext && active && resp_d.respCode == RC_OK
    |=> expect_q == $past(expect_q) + SEQ_STEP)
    else $error("expected chunk did not step");

  a_ready_after_final: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    blockReady |-> $past(take) && $past(opLast)
    && resp_q.respCode == RC_OK && state_q == ST_DONE)
    else $error("block handed on early");

  a_single_xfer: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opFirst && busyNew
    |=> resp_q.reason == RSN_ABORT
    && state_q == $past(state_q))
    else $error("second sequence was opened");

  a_abort_opcode: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opAbort |=> state_q == ST_IDLE [*2])
    else $error("abort left the transfer open");

  a_no_context: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opNext && !active
    |=> resp_q.reason == RSN_ABORT && !xferActive)
    else $error("chunk accepted without context");

  a_storage_full: assert property (@(posedge ref_clk)
    disable iff (!rstSync_q)
    take && opNext && active && seqOk && stageOvf_q
    |=> resp_q.reason == RSN_STORAGE)
    else $error("overflow not reported");

endmodule : cdd_receiver

/* File: rtl/cdd_pkg.sv */
// constants and carrier types for the chunked data download receiver
package cdd_pkg;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  localparam int          MEM_DEPTH = 64;
  localparam int          MEM_AW    = 6;
  localparam logic [6:0]  MEM_WORDS = 7'h40;

  // ---------------------------------------------------------------
  // command and response codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_DOWNLOAD = 8'h4c;
  localparam logic [7:0]  RSP_DOWNLOAD = 8'hcc;
  localparam logic [7:0]  OP_FIRST     = 8'h01;
  localparam logic [7:0]  OP_MIDDLE    = 8'h02;
  localparam logic [7:0]  OP_FINAL     = 8'h04;
  localparam logic [7:0]  OP_ONLY      = 8'h05;
  localparam logic [7:0]  OP_ABORT     = 8'h08;
  localparam logic [15:0] RC_OK        = 16'h0000;
  localparam logic [15:0] RC_FAIL      = 16'h0001;
  localparam logic [15:0] RSN_NONE     = 16'h0000;
  localparam logic [15:0] RSN_ABORT    = 16'h4c01;
  localparam logic [15:0] RSN_HANDLE   = 16'h4c02;
  localparam logic [15:0] RSN_SEQ      = 16'h4c03;
  localparam logic [15:0] RSN_STORAGE  = 16'h4c04;
  localparam logic [15:0] RSN_RESEND   = 16'h4c80;
  localparam logic [15:0] RSN_BADOP    = 16'h0003;
  localparam logic [31:0] SEQ_SECOND   = 32'h0000_0002;
  localparam logic [31:0] SEQ_STEP     = 32'h0000_0001;

  // ---------------------------------------------------------------
  // register map and control bits
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_HANDLE = 8'h04;
  localparam logic [7:0]  REG_STATUS = 8'h08;
  localparam logic [7:0]  REG_EXPECT = 8'h0c;
  localparam logic [7:0]  REG_LEN    = 8'h10;
  localparam logic [7:0]  REG_RDIDX  = 8'h14;
  localparam logic [7:0]  REG_RDDATA = 8'h18;
  localparam logic [7:0]  REG_OFFSET = 8'h1c;
  localparam int          CTRL_STORE_BIT = 0;
  localparam int          CTRL_ANYH_BIT  = 1;
  localparam int          CTRL_CLEAR_BIT = 2;
  localparam logic [2:0]  CTRL_RESET     = 3'h1;

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cmdCode;
    logic [7:0]  opcode;
    logic [31:0] offset;
    logic [31:0] handleChunk;
    logic        partialWord;
    logic        chkOk;
    logic        idOk;
  } cdd_cmd_t;

  typedef struct packed {
    logic [7:0]  rspType;
    logic [15:0] respCode;
    logic [15:0] reason;
  } cdd_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_DONE   = 2'b10
  } cdd_state_t;

endpackage : cdd_pkg

/* File: test/cdd_mc_model.sv */
// management controller model that sends download chunks to the handler
`timescale 1ns/1ns

module cdd_mc_model
  import cdd_pkg::*;
(
  input  wire logic   ref_clk,   // link clock
  output logic        dataValid, // payload word strobe
  output logic [31:0] dataWord,  // payload word
  output logic        cmdValid,  // command trailer strobe
  output cdd_cmd_t    cmd        // command fields
);

  // ---------------------------------------------------------------
  // idle link at time zero
  // ---------------------------------------------------------------
  initial begin
    dataValid = 1'b0;
    dataWord  = 32'h0000_0000;
    cmdValid  = 1'b0;
    cmd       = '0;
  end

  // ---------------------------------------------------------------
  // one chunk: whole double words in order, then the trailer
  // ---------------------------------------------------------------
  // the handle is the caller's, as a transfer-request notice gives it
  task automatic send(input logic [7:0] op, input logic [31:0] hc,
      input int n, input logic [31:0] base, input logic partial,
      input logic chk);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      dataValid <= 1'b1;
      dataWord  <= base + i;
    end
    @(posedge ref_clk);
    dataValid <= 1'b0;
    dataWord  <= ~(base + n - 1); // released word never repeats the last
    cmdValid  <= 1'b1;
    cmd       <= '{cmdCode: CMD_DOWNLOAD, opcode: op, offset: 32'h0000_0000,
                   handleChunk: hc, partialWord: partial, chkOk: chk,
                   idOk: 1'b1};
    @(posedge ref_clk);
    cmdValid  <= 1'b0;
    cmd       <= ~cmd; // fields are stale outside the strobe
  endtask : send

endmodule : cdd_mc_model

/* File: test/cdd_receiver_tb.sv */
// self-checking bench for the download command handler
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin nTests++; if ((got) !== (exp)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end

module cdd_receiver_tb
  import cdd_pkg::*;
;
  localparam logic [31:0] HANDLE = 32'h0000_1234;
  logic        ref_clk, arst_n, otherBusy, regWr, regRd;
  logic        dataValid, cmdValid, respValid, xferActive, blockReady;
  logic [31:0] dataWord, respWord, regWdata, regRdata;
  logic [7:0]  regAddr;
  cdd_cmd_t    cmd;
  cdd_rsp_t    resp;
  int          mismatches, nTests;

  cdd_mc_model mc (.ref_clk(ref_clk), .dataValid(dataValid),
    .dataWord(dataWord), .cmdValid(cmdValid), .cmd(cmd));
  cdd_receiver uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .dataValid(dataValid), .dataWord(dataWord), .cmdValid(cmdValid),
    .cmd(cmd), .otherBusy(otherBusy), .respValid(respValid), .resp(resp),
    .respWord(respWord), .xferActive(xferActive), .blockReady(blockReady),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));

  // ---------------------------------------------------------------
  // clock and bus tasks
  // ---------------------------------------------------------------
  always #50 ref_clk = ~ref_clk;

  task automatic do_reset;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk); // two sync flops before first request
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1;
    `CHK("regRdata", exp, regRdata)
  endtask : rd

  // sends one chunk, then looks at the one-cycle response
  task automatic chunk(input logic [7:0] op, input logic [31:0] hc,
      input int n, input logic [31:0] base, input logic partial,
      input logic chk, input logic [15:0] rc, input logic [15:0] rsn,
      input logic done);
    mc.send(op, hc, n, base, partial, chk);
    #1;
    `CHK("respValid", chk, respValid)
    if (chk) begin
      `CHK("rspType", RSP_DOWNLOAD, resp.rspType)
      `CHK("respWord", {rc, rsn}, respWord)
      `CHK("blockReady", done, blockReady)
    end
  endtask : chunk

  task automatic test_end(input string nm);
    $display("test %s done", nm);
  endtask : test_end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // watchdog: the whole sequence needs well under a thousand cycles
  // ---------------------------------------------------------------
  initial begin
    repeat (4000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk    = 1'b0;
    arst_n     = 1'b0;
    otherBusy  = 1'b0;
    regWr      = 1'b0;
    regRd      = 1'b0;
    regAddr    = 8'h00;
    regWdata   = 32'h0000_0000;
    mismatches = 0;
    nTests     = 0;
    do_reset();
    rd(REG_CTRL, {29'h0, CTRL_RESET});
    rd(REG_STATUS, 32'h0000_0000);
    rd(8'hfc, 32'h0000_0000); // unmapped place reads zero
    wr(REG_HANDLE, HANDLE);
    test_end("reset");
    chunk(OP_ONLY, HANDLE, 2, 32'h100, 0, 1, RC_OK, RSN_NONE, 1);
    rd(REG_STATUS, 32'h0000_0002);
    wr(REG_RDIDX, 32'h1);
    rd(REG_RDDATA, 32'h101);
    test_end("single");
    chunk(OP_FIRST, HANDLE, 2, 32'h200, 0, 1, RC_OK, RSN_NONE, 0);
    rd(REG_EXPECT, SEQ_SECOND);
    chunk(OP_MIDDLE, 2, 2, 32'h300, 0, 1, RC_OK, RSN_NONE, 0);
    rd(REG_EXPECT, 32'h3);
    chunk(OP_FINAL, 3, 1, 32'h400, 0, 1, RC_OK, RSN_NONE, 1);
    `CHK("xferActive", 1'b0, xferActive)
    rd(REG_LEN, 32'h5);
    wr(REG_RDIDX, 32'h2);
    rd(REG_RDDATA, 32'h300);
    test_end("multi");
    wr(REG_CTRL, 32'h5);
    chunk(OP_FIRST, HANDLE, 1, 32'h500, 0, 1, RC_OK, RSN_NONE, 0);
    chunk(OP_FIRST, HANDLE, 1, 32'h510, 0, 1, RC_FAIL, RSN_ABORT, 0);
    chunk(OP_MIDDLE, 2, 1, 32'h520, 1, 1, RC_FAIL, RSN_RESEND, 0);
    rd(REG_EXPECT, SEQ_SECOND);
    chunk(OP_MIDDLE, 4, 1, 32'h530, 0, 1, RC_FAIL, RSN_SEQ, 0);
    `CHK("xferActive", 1'b0, xferActive)
    chunk(OP_MIDDLE, 2, 1, 32'h540, 0, 1, RC_FAIL, RSN_ABORT, 0);
    test_end("sequence");
    chunk(OP_FIRST, 32'h0dea_0001, 1, 32'h600, 0, 1, RC_FAIL,
          RSN_HANDLE, 0);
    chunk(8'h03, 2, 1, 32'h610, 0, 1, RC_FAIL, RSN_BADOP, 0);
    chunk(OP_FIRST, HANDLE, 1, 32'h620, 0, 0, RC_OK, RSN_NONE, 0);
    `CHK("xferActive", 1'b0, xferActive)
    otherBusy <= 1'b1;
    chunk(OP_FIRST, HANDLE, 1, 32'h630, 0, 1, RC_FAIL, RSN_ABORT, 0);
    otherBusy <= 1'b0;
    wr(REG_CTRL, 32'h0);
    chunk(OP_FIRST, HANDLE, 1, 32'h640, 0, 1, RC_FAIL, RSN_STORAGE, 0);
    wr(REG_CTRL, 32'h3);
    chunk(OP_ONLY, 32'h0dea_0001, 1, 32'h650, 0, 1, RC_OK, RSN_NONE, 1);
    chunk(OP_ONLY, HANDLE, 1, 32'h660, 0, 1, RC_OK, RSN_NONE, 1);
    test_end("refusals");
    chunk(OP_FIRST, HANDLE, 1, 32'h700, 0, 1, RC_OK, RSN_NONE, 0);
    chunk(OP_ABORT, 2, 0, 32'h710, 0, 1, RC_OK, RSN_NONE, 0);
    `CHK("xferActive", 1'b0, xferActive)
    chunk(OP_MIDDLE, 2, 1, 32'h720, 0, 1, RC_FAIL, RSN_ABORT, 0);
    test_end("abort");
    chunk(OP_FIRST, HANDLE, 40, 32'h800, 0, 1, RC_OK, RSN_NONE, 0);
    chunk(OP_MIDDLE, 2, 30, 32'h900, 0, 1, RC_FAIL, RSN_STORAGE, 0);
    test_end("storage");
    do_reset();
    wr(REG_HANDLE, HANDLE); // reset dropped the supported handle
    chunk(OP_FIRST, HANDLE, 1, 32'ha00, 0, 1, RC_OK, RSN_NONE, 0);
    `CHK("xferActive", 1'b1, xferActive)
    do_reset();
    `CHK("xferActive", 1'b0, xferActive)
    chunk(OP_MIDDLE, 2, 1, 32'ha10, 0, 1, RC_FAIL, RSN_ABORT, 0);
    test_end("context");
    wrap_up();
  end

endmodule : cdd_receiver_tb
